/* logic/fspc_page_buf.sv */
// temporary page buffer, written word by word, cleared as a whole
`timescale 1ns/1ns
module fspc_page_buf #(
  parameter int WORD_BITS = 7,
  parameter int DW        = 16
) (
  input  wire logic                 clk_sys,
  input  wire logic                 srst,
  input  wire logic                 wr_en,
  input  wire logic [WORD_BITS-1:0] wr_idx,
  input  wire logic [DW-1:0]        wr_data,
  input  wire logic                 clr,
  input  wire logic [WORD_BITS-1:0] rd_idx,
  output logic      [DW-1:0]        rd_data_q
);
  localparam int WORDS = 1 << WORD_BITS;

  logic [DW-1:0]    mem_q [WORDS];
  logic [DW-1:0]    mem_d [WORDS];
  logic [WORDS-1:0] used_q;
  logic [WORDS-1:0] used_d;
  logic [DW-1:0]    rd_data_d;

  // a word is taken once per clear; a repeat load keeps the first value
  always_comb begin
    mem_d  = mem_q;
    used_d = used_q;
    if (clr) begin // R22
      used_d = '0;
      for (int i = 0; i < WORDS; i++) begin
        mem_d[i] = '1;
      end
    end else if (wr_en && !used_q[wr_idx]) begin // R21 R23
      mem_d[wr_idx]  = wr_data;
      used_d[wr_idx] = 1'b1;
    end
    rd_data_d = mem_q[rd_idx];
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin // R22
      used_q    <= '0;
      rd_data_q <= '1;
      for (int i = 0; i < WORDS; i++) begin
        mem_q[i] <= '1;
      end
    end else begin
      used_q    <= used_d;
      mem_q     <= mem_d;
      rd_data_q <= rd_data_d;
    end
  end
endmodule

/* logic/fspc_top.sv */
// flash self-program controller with its control register on axi4-lite
// Behaviour
// R1: reset vector chosen by boot vector fuse
// R2: fuses are read only from inside
// R3: ready irq while enabled and store idle
// R4: busy flag set by concurrent-section programming
// R5: busy cleared by reenable or page fill
// R6: signature read on load, store ignored
// R7: reenable only after programming has finished
// R8: reenable command discards page buffer contents
// R9: lock set takes bits from r0
// R10: lock command load returns lock or fuse
// R11: page write from buffer, page from z
// R12: page erase, page from z
// R13: halting section programming stops the cpu
// R14: plain store fills buffer word from r1:r0
// R15: store window four cycles, held while busy
// R16: only five lower patterns are accepted
// R17: target page latched at operation start
// R18: loads address flash by byte
// R19: software sets page field before erase
// R20: software erases before writing same page
// R21: buffer words written in any order
// R22: buffer cleared after write, reenable, reset
// R23: each buffer word loads once per clear
// R24: window counted in cycles from the write
// R25: reset clears commands, busy and window
`timescale 1ns/1ns
module fspc_top #(
  parameter logic [fspc_pkg::PAGE_W-1:0] HALT_PAGE_FIRST = 16'h0070,
  parameter logic [15:0]                 BOOT_VECTOR     = 16'h7000,
  // signature row contents, arbitrary values
  parameter logic [31:0]                 SIG_ROW         = 32'h5a3c_96e1
) (
  input  wire logic                                clk_sys,
  input  wire logic                                srst,
  input  wire logic [fspc_pkg::AXI_AW-1:0]          s_axi_awaddr,
  input  wire logic                                s_axi_awvalid,
  output logic                                     s_axi_awready,
  input  wire logic [31:0]                         s_axi_wdata,
  input  wire logic [3:0]                          s_axi_wstrb,
  input  wire logic                                s_axi_wvalid,
  output logic                                     s_axi_wready,
  output logic [1:0]                               s_axi_bresp,
  output logic                                     s_axi_bvalid,
  input  wire logic                                s_axi_bready,
  input  wire logic [fspc_pkg::AXI_AW-1:0]          s_axi_araddr,
  input  wire logic                                s_axi_arvalid,
  output logic                                     s_axi_arready,
  output logic [31:0]                              s_axi_rdata,
  output logic [1:0]                               s_axi_rresp,
  output logic                                     s_axi_rvalid,
  input  wire logic                                s_axi_rready,
  input  wire fspc_pkg::fspc_cpu_req_s             cpu_req,
  input  wire logic                                cpu_gie,
  output logic [7:0]                               load_data,
  output logic                                     load_valid,
  output logic                                     load_blocked,
  output logic                                     ready_irq,
  output logic                                     cpu_halt,
  output logic                                     concurrent_section_busy,
  output logic [15:0]                              reset_vector,
  input  wire logic                                boot_vector_fuse,
  input  wire logic [7:0]                          fuse_low,
  input  wire logic [7:0]                          fuse_high,
  output logic [fspc_pkg::ADDR_W-1:0]               flash_rd_addr,
  input  wire logic [7:0]                          flash_rd_data,
  output fspc_pkg::fspc_flash_op_s                 flash_op,
  input  wire logic                                flash_done,
  input  wire logic [fspc_pkg::WORD_BITS-1:0]       flash_buf_idx,
  output logic [15:0]                              flash_buf_data
);
  localparam int WB = fspc_pkg::WORD_BITS;
  localparam int PW = fspc_pkg::PAGE_W;

  function automatic logic legal_cmd(input logic [4:0] p);
    legal_cmd = (p == fspc_pkg::CMD_REEN) || (p == fspc_pkg::CMD_LOCK) ||
                (p == fspc_pkg::CMD_WRITE) || (p == fspc_pkg::CMD_ERASE) ||
                (p == fspc_pkg::CMD_FILL); // R16
  endfunction

  function automatic logic [PW-1:0] page_of(input logic [7:0] e,
                                            input logic [15:0] z);
    logic [fspc_pkg::ADDR_W-1:0] a;
    a       = {e, z};
    page_of = a[fspc_pkg::ADDR_W-1:WB+1];
  endfunction

  function automatic logic in_halt(input logic [PW-1:0] pg);
    in_halt = (pg >= HALT_PAGE_FIRST);
  endfunction

  // fuse pins from outside pass two flops before use
  logic [16:0] fuse_s1_q;
  logic [16:0] fuse_s2_q;
  logic        boot_fuse;
  logic [7:0]  fl_lo;
  logic [7:0]  fl_hi;
  always_ff @(posedge clk_sys) begin
    fuse_s1_q <= {boot_vector_fuse, fuse_high, fuse_low};
    fuse_s2_q <= fuse_s1_q;
  end
  assign boot_fuse = fuse_s2_q[16];
  assign fl_hi     = fuse_s2_q[15:8];
  assign fl_lo     = fuse_s2_q[7:0];

  // bus slave state, one write and one read at a time
  logic                       aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
  logic [fspc_pkg::AXI_AW-1:0] awaddr_q, awaddr_d;
  logic [7:0]                 wbyte_q, wbyte_d;
  logic                       wlane_q, wlane_d;
  logic                       awready_d, wready_d, arready_d;
  logic                       bvalid_d, rvalid_d;
  logic [1:0]                 bresp_d, rresp_d;
  logic [31:0]                rdata_d;
  logic                       commit, ctrl_wr;
  logic [7:0]                 wdat;

  // controller state
  fspc_pkg::fspc_state_e       st_q, st_d;
  logic [5:0]                  cmd_q, cmd_d;
  logic                        ie_q, ie_d, busy_q, busy_d, halt_d;
  logic [2:0]                  win_q, win_d;
  logic [fspc_pkg::LOCK_W-1:0] lock_q, lock_d;
  fspc_pkg::fspc_flash_op_s    op_d;
  fspc_pkg::fspc_load_e        ldk_q, ldk_d;
  logic [7:0]                  ldv_q, ldv_d;
  logic [fspc_pkg::ADDR_W-1:0] rda_d;
  logic                        buf_wr, buf_clr, spec_ld, irq_cause;
  logic [PW-1:0]               zpage;
  logic [7:0]                  ld_out_d;

  assign commit  = aw_hold_q && w_hold_q && !s_axi_bvalid;
  assign ctrl_wr = commit && (awaddr_q == fspc_pkg::CTRL_ADDR) && wlane_q;
  assign wdat    = wbyte_q;
  assign zpage   = page_of(cpu_req.z_ext, cpu_req.z);
  assign spec_ld = (st_q == fspc_pkg::ST_WINDOW) && cpu_req.load &&
                   (win_q > fspc_pkg::STORE_WIN - fspc_pkg::LOAD_WIN) &&
                   (cmd_q[fspc_pkg::BIT_SIG] ||
                    cmd_q[4:0] == fspc_pkg::CMD_LOCK);
  assign irq_cause = ie_q && cpu_gie && !cmd_q[fspc_pkg::BIT_EN];

  always_comb begin
    aw_hold_d = aw_hold_q;
    w_hold_d  = w_hold_q;
    awaddr_d  = awaddr_q;
    wbyte_d   = wbyte_q;
    wlane_d   = wlane_q;
    bvalid_d  = s_axi_bvalid;
    bresp_d   = s_axi_bresp;
    rvalid_d  = s_axi_rvalid;
    rresp_d   = s_axi_rresp;
    rdata_d   = s_axi_rdata;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_d = 1'b1;
      awaddr_d  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_hold_d = 1'b1;
      wbyte_d  = s_axi_wdata[7:0];
      wlane_d  = s_axi_wstrb[0];
    end
    if (commit) begin
      aw_hold_d = 1'b0;
      w_hold_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = (awaddr_q == fspc_pkg::CTRL_ADDR ||
                   awaddr_q == fspc_pkg::STATUS_ADDR) ?
                  fspc_pkg::RESP_OKAY : fspc_pkg::RESP_SLVERR;
    end else if (s_axi_bvalid && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'b1;
      rresp_d  = fspc_pkg::RESP_OKAY;
      rdata_d  = '0;
      if (s_axi_araddr == fspc_pkg::CTRL_ADDR) begin
        rdata_d[7:0] = {ie_q, busy_q, cmd_q};
      end else if (s_axi_araddr == fspc_pkg::STATUS_ADDR) begin
        rdata_d[15:0] = {lock_q, cpu_halt, boot_fuse, 6'h00, st_q};
      end else begin
        rresp_d = fspc_pkg::RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    awready_d = !aw_hold_d && !bvalid_d;
    wready_d  = !w_hold_d && !bvalid_d;
    arready_d = !rvalid_d;
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      aw_hold_q     <= 1'b0;
      w_hold_q      <= 1'b0;
      awaddr_q      <= '0;
      wbyte_q       <= '0;
      wlane_q       <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_arready <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= fspc_pkg::RESP_OKAY;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= fspc_pkg::RESP_OKAY;
      s_axi_rdata   <= '0;
    end else begin
      aw_hold_q     <= aw_hold_d;
      w_hold_q      <= w_hold_d;
      awaddr_q      <= awaddr_d;
      wbyte_q       <= wbyte_d;
      wlane_q       <= wlane_d;
      s_axi_awready <= awready_d;
      s_axi_wready  <= wready_d;
      s_axi_arready <= arready_d;
      s_axi_bvalid  <= bvalid_d;
      s_axi_bresp   <= bresp_d;
      s_axi_rvalid  <= rvalid_d;
      s_axi_rresp   <= rresp_d;
      s_axi_rdata   <= rdata_d;
    end
  end

  // command sequencer; fuses have no write path at all (R2)
  always_comb begin
    st_d     = st_q;
    cmd_d    = cmd_q;
    ie_d     = ie_q;
    busy_d   = busy_q;
    halt_d   = cpu_halt;
    win_d    = win_q;
    lock_d   = lock_q;
    op_d     = flash_op;
    op_d.start = 1'b0;
    buf_wr   = 1'b0;
    buf_clr  = 1'b0;
    if (ctrl_wr) begin
      ie_d = wdat[fspc_pkg::BIT_IE];
    end
    unique case (st_q)
      fspc_pkg::ST_IDLE: begin
        if (ctrl_wr && legal_cmd(wdat[4:0])) begin // R16
          cmd_d = {wdat[fspc_pkg::BIT_SIG] &&
                   (wdat[4:0] == fspc_pkg::CMD_FILL), wdat[4:0]};
          win_d = fspc_pkg::STORE_WIN; // R24
          st_d  = fspc_pkg::ST_WINDOW;
          if (wdat[4:0] == fspc_pkg::CMD_REEN) begin
            buf_clr = 1'b1; // R8
          end
        end
      end
      fspc_pkg::ST_WINDOW: begin
        if (cpu_req.store) begin
          st_d  = fspc_pkg::ST_IDLE;
          cmd_d = '0; // R15
          if (cmd_q[fspc_pkg::BIT_SIG]) begin
            cmd_d = '0; // R6
          end else if (cmd_q[4:0] == fspc_pkg::CMD_FILL) begin
            buf_wr = 1'b1; // R14
            busy_d = 1'b0; // R5
          end else if (cmd_q[4:0] == fspc_pkg::CMD_LOCK) begin
            lock_d = lock_q & cpu_req.r0[fspc_pkg::LOCK_W-1:0]; // R9
          end else if (cmd_q[4:0] == fspc_pkg::CMD_REEN) begin
            busy_d  = 1'b0; // R5 R7
            buf_clr = 1'b1; // R22
          end else begin
            st_d       = fspc_pkg::ST_BUSY;
            cmd_d      = cmd_q; // R15
            op_d.start = 1'b1;
            op_d.erase = (cmd_q[4:0] == fspc_pkg::CMD_ERASE); // R12
            op_d.write = (cmd_q[4:0] == fspc_pkg::CMD_WRITE); // R11
            op_d.page  = zpage; // R17
            halt_d     = in_halt(zpage); // R13
            busy_d     = busy_q || !in_halt(zpage); // R4
          end
        end else if (spec_ld) begin
          st_d  = fspc_pkg::ST_IDLE; // R10
          cmd_d = '0;
        end else if (win_q == 3'h1) begin
          st_d  = fspc_pkg::ST_IDLE; // R24
          cmd_d = '0;
        end else begin
          win_d = win_q - 3'h1;
        end
      end
      fspc_pkg::ST_BUSY: begin
        if (flash_done) begin
          st_d   = fspc_pkg::ST_IDLE;
          cmd_d  = '0; // R15
          halt_d = 1'b0; // R13
          if (flash_op.write) begin
            buf_clr = 1'b1; // R22
          end
        end
      end
      default: st_d = fspc_pkg::ST_IDLE;
    endcase
  end

  // load path: address now, answer two edges after the load
  always_comb begin
    ldk_d = fspc_pkg::LD_NONE;
    ldv_d = fspc_pkg::BLOCKED_VAL;
    rda_d = flash_rd_addr;
    if (cpu_req.load) begin
      rda_d = {cpu_req.z_ext, cpu_req.z}; // R18
      if (spec_ld && cmd_q[fspc_pkg::BIT_SIG]) begin
        ldk_d = fspc_pkg::LD_SPECIAL; // R6
        ldv_d = SIG_ROW[{cpu_req.z[2:1], 3'h0} +: 8];
      end else if (spec_ld) begin
        ldk_d = fspc_pkg::LD_SPECIAL; // R10
        ldv_d = cpu_req.z[0] ? {fspc_pkg::LOCK_PAD, lock_q} :
                cpu_req.z[1] ? fl_hi : fl_lo;
      end else if (busy_q && !in_halt(zpage)) begin
        ldk_d = fspc_pkg::LD_BLOCKED; // R4
      end else begin
        ldk_d = fspc_pkg::LD_FLASH;
      end
    end
    ld_out_d = (ldk_q == fspc_pkg::LD_FLASH) ? flash_rd_data : ldv_q;
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin // R25
      st_q          <= fspc_pkg::ST_IDLE;
      cmd_q         <= '0;
      ie_q          <= 1'b0;
      busy_q        <= 1'b0;
      win_q         <= '0;
      lock_q        <= fspc_pkg::LOCK_RST;
      flash_op      <= '0;
      cpu_halt      <= 1'b0;
      ready_irq     <= 1'b0;
      ldk_q         <= fspc_pkg::LD_NONE;
      ldv_q         <= '0;
      flash_rd_addr <= '0;
      load_data     <= '0;
      load_valid    <= 1'b0;
      load_blocked  <= 1'b0;
      reset_vector  <= fspc_pkg::APP_VECTOR;
      concurrent_section_busy <= 1'b0;
    end else begin
      st_q          <= st_d;
      cmd_q         <= cmd_d;
      ie_q          <= ie_d;
      busy_q        <= busy_d;
      win_q         <= win_d;
      lock_q        <= lock_d;
      flash_op      <= op_d;
      cpu_halt      <= halt_d;
      ready_irq     <= irq_cause; // R3
      ldk_q         <= ldk_d;
      ldv_q         <= ldv_d;
      flash_rd_addr <= rda_d;
      load_data     <= ld_out_d;
      load_valid    <= (ldk_q != fspc_pkg::LD_NONE);
      load_blocked  <= (ldk_q == fspc_pkg::LD_BLOCKED);
      reset_vector  <= boot_fuse ? fspc_pkg::APP_VECTOR : BOOT_VECTOR; // R1
      concurrent_section_busy <= busy_d;
    end
  end

  fspc_page_buf #(
    .WORD_BITS (WB),
    .DW        (16)
  ) u_buf (
    .clk_sys   (clk_sys),
    .srst      (srst),
    .wr_en     (buf_wr),
    .wr_idx    (cpu_req.z[WB:1]),
    .wr_data   ({cpu_req.r1, cpu_req.r0}),
    .clr       (buf_clr),
    .rd_idx    (flash_buf_idx),
    .rd_data_q (flash_buf_data)
  );

  logic st_store;
  assign st_store = (st_q == fspc_pkg::ST_WINDOW) && cpu_req.store;

  a_irq_level: // R3
    assert property (@(posedge clk_sys) disable iff (srst)
      irq_cause |=> ready_irq)
    else $error("ready irq not raised");
  a_busy_set: // R4
    assert property (@(posedge clk_sys) disable iff (srst)
      st_store && cmd_q[4:0] == fspc_pkg::CMD_ERASE && !in_halt(zpage)
      |=> busy_q && st_q == fspc_pkg::ST_BUSY)
    else $error("busy flag not set on erase");
  a_block_read: // R4
    assert property (@(posedge clk_sys) disable iff (srst)
      cpu_req.load && !spec_ld && busy_q && !in_halt(zpage)
      |-> ##2 load_blocked && load_valid)
    else $error("read of busy section not blocked");
  a_fill_clears: // R5
    assert property (@(posedge clk_sys) disable iff (srst)
      st_store && cmd_q == {1'b0, fspc_pkg::CMD_FILL} |=> !busy_q)
    else $error("page fill did not clear busy");
  a_window_expiry: // R15
    assert property (@(posedge clk_sys) disable iff (srst)
      (st_q == fspc_pkg::ST_IDLE && ctrl_wr && legal_cmd(wdat[4:0]))
      ##1 (!cpu_req.store && !cpu_req.load)[*4] |=> cmd_q == '0)
    else $error("store window not closed after four cycles");
  a_busy_holds_en: // R15
    assert property (@(posedge clk_sys) disable iff (srst)
      st_q == fspc_pkg::ST_BUSY && !flash_done |=> cmd_q[fspc_pkg::BIT_EN])
    else $error("store enable dropped during operation");
  a_halt_halting_section: // R13
    assert property (@(posedge clk_sys) disable iff (srst)
      st_store && cmd_q[4:0] == fspc_pkg::CMD_WRITE && in_halt(zpage)
      |=> cpu_halt throughout (st_q == fspc_pkg::ST_BUSY))
    else $error("cpu not halted for halting section");
  a_lock_read: // R10
    assert property (@(posedge clk_sys) disable iff (srst)
      spec_ld && !cmd_q[fspc_pkg::BIT_SIG] && cpu_req.z[0]
      |-> ##2 load_data == {fspc_pkg::LOCK_PAD, lock_q})
    else $error("lock read returned wrong value");
  a_illegal_cmd: // R16
    assert property (@(posedge clk_sys) disable iff (srst)
      st_q == fspc_pkg::ST_IDLE && ctrl_wr && !legal_cmd(wdat[4:0])
      |=> st_q == fspc_pkg::ST_IDLE && cmd_q == '0)
    else $error("illegal pattern accepted");

  c_erase: cover property (@(posedge clk_sys) disable iff (srst)
    st_q == fspc_pkg::ST_BUSY ##1 flash_done);
  c_fill: cover property (@(posedge clk_sys) disable iff (srst)
    st_store && cmd_q[4:0] == fspc_pkg::CMD_FILL);
  c_lock_read: cover property (@(posedge clk_sys) disable iff (srst)
    spec_ld ##2 load_valid);
endmodule

/* pkg/fspc_pkg.sv */
// shared constants and carriers of the flash self-program controller
package fspc_pkg;
  // register map, byte addresses on the bus
  localparam int          AXI_AW      = 8;
  localparam logic [7:0]  CTRL_IDX    = 8'h37;
  localparam logic [7:0]  CTRL_ADDR   = 8'hdc;
  localparam logic [7:0]  STATUS_ADDR = 8'h00;
  localparam logic [7:0]  CTRL_RST    = 8'h00;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  // control field positions
  localparam int BIT_IE   = 7;
  localparam int BIT_BUSY = 6;
  localparam int BIT_SIG  = 5;
  localparam int BIT_EN   = 0;
  // accepted lower five bit patterns
  localparam logic [4:0] CMD_REEN  = 5'h11;
  localparam logic [4:0] CMD_LOCK  = 5'h09;
  localparam logic [4:0] CMD_WRITE = 5'h05;
  localparam logic [4:0] CMD_ERASE = 5'h03;
  localparam logic [4:0] CMD_FILL  = 5'h01;
  // windows in clock cycles after the control write
  localparam logic [2:0] STORE_WIN = 3'h4;
  localparam logic [2:0] LOAD_WIN  = 3'h3;
  // flash addressing
  localparam int ADDR_W    = 24;
  localparam int WORD_BITS = 7;
  localparam int PAGE_W    = ADDR_W - 1 - WORD_BITS;
  localparam int LOCK_W    = 6;
  localparam logic [LOCK_W-1:0] LOCK_RST = 6'h3f;
  localparam logic [1:0]  LOCK_PAD    = 2'h3;
  localparam logic [7:0]  BLOCKED_VAL = 8'hff;
  localparam logic [15:0] APP_VECTOR  = 16'h0000;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_WINDOW = 2'b01,
    ST_BUSY   = 2'b10
  } fspc_state_e;

  typedef enum logic [1:0] {
    LD_NONE    = 2'b00,
    LD_FLASH   = 2'b01,
    LD_SPECIAL = 2'b10,
    LD_BLOCKED = 2'b11
  } fspc_load_e;

  // store or load instruction issued by the core
  typedef struct packed {
    logic        store;
    logic        load;
    logic [7:0]  z_ext;
    logic [15:0] z;
    logic [7:0]  r1;
    logic [7:0]  r0;
  } fspc_cpu_req_s;

  // programming request towards the flash array
  typedef struct packed {
    logic              start;
    logic              erase;
    logic              write;
    logic [PAGE_W-1:0] page;
  } fspc_flash_op_s;
endpackage

/* testbench/fspc_flash_model.sv */
// flash array stand-in: combinational read data, done pulse after a delay
`timescale 1ns/1ns
module fspc_flash_model #(
  parameter int DLY = 5
) (
  input  wire logic                        clk_sys,
  input  wire logic                        srst,
  input  wire logic [fspc_pkg::ADDR_W-1:0] flash_rd_addr,
  output logic      [7:0]                  flash_rd_data,
  input  wire fspc_pkg::fspc_flash_op_s    flash_op,
  output logic                             flash_done
);
  int cnt_q;
  // data must follow the address at once, the controller samples it directly
  assign flash_rd_data = flash_rd_addr[23:16] ^ flash_rd_addr[7:0] ^ 8'h5a;
  always_ff @(posedge clk_sys) begin
    flash_done <= !srst && !flash_op.start && (cnt_q == 1);
    if (srst) begin
      cnt_q <= 0;
    end else if (flash_op.start) begin
      cnt_q <= DLY;
    end else if (cnt_q > 0) begin
      cnt_q <= cnt_q - 1;
    end
  end
endmodule

/* testbench/tb_flash_self_program_control.sv */
// self-checking bench for the flash self-program controller
`timescale 1ns/1ns
module tb_flash_self_program_control;
  typedef struct packed {
    logic [7:0] wr;
    logic       gie;
    logic [7:0] rd;
    logic       irq;
  } fspc_row_s;
  fspc_row_s rows [6] = '{'{8'h80, 1'b1, 8'h80, 1'b1},
    '{8'h9f, 1'b0, 8'h80, 1'b0}, '{8'h81, 1'b1, 8'h81, 1'b0},
    '{8'hc0, 1'b1, 8'h80, 1'b1}, '{8'h07, 1'b1, 8'h00, 1'b0},
    '{8'h1e, 1'b1, 8'h00, 1'b0}};
  logic clk_sys, srst, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, cpu_gie, load_valid;
  logic load_blocked, ready_irq, cpu_halt, concurrent_section_busy;
  logic boot_vector_fuse, flash_done;
  logic [7:0] s_axi_awaddr, s_axi_araddr, load_data, fuse_low, fuse_high;
  logic [7:0] flash_rd_data;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [15:0] reset_vector, flash_buf_data;
  logic [6:0] flash_buf_idx;
  logic [23:0] flash_rd_addr;
  fspc_pkg::fspc_cpu_req_s cpu_req;
  fspc_pkg::fspc_flash_op_s flash_op;
  int n_errors, checks_done, cyc;
  localparam logic [7:0] CA = fspc_pkg::CTRL_ADDR;

  fspc_top fspc_top_i (.*);
  fspc_flash_model #(.DLY(20)) fspc_flash_model_i (.*);

  task automatic final_report();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, exp, input string m);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [7:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    {s_axi_awvalid, s_axi_wvalid} <= 2'b11;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
  endtask
  task automatic axr(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
  endtask
  // one-cycle store or load pulse; returns one cycle after the taking edge
  task automatic cpu(input logic st, input logic [23:0] z, input [15:0] r);
    cpu_req <= '{st, !st, z[23:16], z[15:0], r[15:8], r[7:0]};
    @(posedge clk_sys);
    cpu_req.store <= 1'b0;
    cpu_req.load <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic ld(input logic [23:0] z, input logic [9:0] e);
    cpu(1'b0, z, 16'h0);
    @(posedge clk_sys);
    cmp({load_valid, load_blocked, load_data}, e, "load");
  endtask
  task automatic chkbuf(input logic [6:0] i, input logic [15:0] e);
    @(posedge clk_sys);
    flash_buf_idx <= i;
    repeat (2) @(posedge clk_sys);
    cmp(flash_buf_data, e, "buf");
  endtask
  task automatic cmd(input logic [7:0] c, input logic [23:0] z, input [15:0] r);
    axw(CA, c);
    cpu(1'b1, z, r);
  endtask
  task automatic wait_done();
    // no limit of its own: the hang guard ends a wait that never returns
    while (flash_done !== 1'b1) @(posedge clk_sys);
    repeat (2) @(posedge clk_sys);
  endtask
  task automatic do_reset();
    srst <= 1'b1;
    repeat (6) @(posedge clk_sys);
    srst <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // hang guard, far above the few hundred cycles the run needs
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors++;
      final_report();
    end
  end

  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {cpu_req, flash_buf_idx} = '0;
    // answers are always taken at once, so back-to-back calls never clash
    {s_axi_bready, s_axi_rready} = 2'b11;
    s_axi_wstrb = 4'hf;
    cpu_gie = 1'b1;
    boot_vector_fuse = 1'b1;
    fuse_low = 8'h96;
    fuse_high = 8'h69;
    do_reset();
    cmp(reset_vector, 16'h0000, "vec");
    axr(fspc_pkg::STATUS_ADDR);
    cmp(rd, 32'h0000fd00, "stat");
    axw(fspc_pkg::STATUS_ADDR, 8'hff);
    axr(fspc_pkg::STATUS_ADDR);
    cmp(rd, 32'h0000fd00, "ro");
    axr(8'h40);
    cmp(rsp, fspc_pkg::RESP_SLVERR, "map");
    axw(8'h40, 8'h00);
    cmp(rsp, fspc_pkg::RESP_SLVERR, "wmap");
    chkbuf(7'd2, 16'hffff);
    foreach (rows[k]) begin
      cpu_gie <= rows[k].gie;
      axw(CA, rows[k].wr);
      axr(CA);
      cmp(rd, {24'h0, rows[k].rd}, "ctrl");
      cmp(ready_irq, rows[k].irq, "irq");
    end
    cmd(8'h01, 24'h000005, 16'habcd);
    chkbuf(7'd2, 16'habcd);
    cmd(8'h01, 24'h000004, 16'h1234);
    chkbuf(7'd2, 16'habcd);
    cmd(8'h01, 24'h000000, 16'h5555);
    chkbuf(7'd0, 16'h5555);
    cmd(8'h03, 24'h000300, 16'h0);
    cmp({flash_op.start, flash_op.erase, flash_op.page}, 18'h30003, "ers");
    cmp({concurrent_section_busy, cpu_halt}, 2'b10, "busy");
    wait_done();
    ld(24'h000010, 10'h3ff);
    cmd(8'h11, 24'h0, 16'h0);
    cmp(concurrent_section_busy, 1'b0, "reen");
    chkbuf(7'd2, 16'hffff);
    cmd(8'h03, 24'h007000, 16'h0);
    wait_done();
    cmd(8'h05, 24'h007000, 16'h0);
    cmp({flash_op.write, flash_op.page, cpu_halt}, 18'h200e1, "wr");
    axr(CA);
    cmp(rd, 32'h5, "held");
    wait_done();
    cmp({cpu_halt, concurrent_section_busy}, 2'b00, "halt");
    axw(CA, 8'h09);
    ld(24'h000001, 10'h2ff);
    axw(CA, 8'h09);
    ld(24'h000000, 10'h296);
    ld(24'h010005, 10'h25e);
    axw(CA, 8'h01);
    repeat (5) @(posedge clk_sys);
    cpu(1'b1, 24'h000006, 16'h7777);
    chkbuf(7'd3, 16'hffff);
    cmd(8'h21, 24'h000004, 16'h4444);
    chkbuf(7'd2, 16'hffff);
    axw(CA, 8'h21);
    ld(24'h000004, 10'h23c);
    cmd(8'h09, 24'h000001, 16'h0030);
    repeat (4) @(posedge clk_sys);
    axr(fspc_pkg::STATUS_ADDR);
    cmp(rd & 32'hfc00, 32'hc000, "lock");
    boot_vector_fuse <= 1'b0;
    do_reset();
    cmp(reset_vector, 16'h7000, "boot");
    axr(fspc_pkg::STATUS_ADDR);
    cmp(rd, 32'h0000fc00, "stat2");
    final_report();
  end
endmodule
